// File: include/qpd_filt_if.sv
`timescale 1ns/10ps
interface qpd_filt_if;
   logic sample;
   logic [2:0] count;
   logic raw;
   logic filt;
   modport ctrl (output sample, output count, output raw, input filt);
   modport filt_end (input sample, input count, input raw, output filt);
endinterface

// File: include/qpd_pkg.sv
package qpd_pkg;
   // ----------------------------------------
   // Trigger modes
   // ----------------------------------------
   localparam logic [1:0] TRIG_OFF = 2'h0;
   localparam logic [1:0] TRIG_RISE = 2'h1;
   localparam logic [1:0] TRIG_FALL = 2'h2;
   // ----------------------------------------
   // Flag bit positions
   // ----------------------------------------
   localparam int FLG_MARK = 0;
   localparam int FLG_TURN = 1;
   localparam int FLG_WDOG = 2;
   localparam int FLG_CMP = 3;
   localparam int FLG_ROVR = 4;
   localparam int FLG_RUND = 5;
   localparam int NUM_FLAGS = 6;
   // ----------------------------------------
   // Filter and reset constants
   // ----------------------------------------
   localparam logic [3:0] FILT_MIN_SAMPLES = 4'h3;
   localparam logic [15:0] POS_RESET = 16'h0000;
   localparam logic [31:0] CMP_RESET = 32'hFFFFFFFF;
endpackage

// File: rtl/qpd_decoder.sv
`timescale 1ns/10ps
module qpd_decoder
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Encoder inputs
   input wire logic quad_chan_a_in,
   input wire logic quad_chan_b_in,
   input wire logic marker_in,
   input wire logic turn_pulse_in,
   // Configuration
   input wire logic single_phase_in,
   input wire logic reverse_in,
   input wire logic [1:0] marker_trig_in,
   input wire logic [1:0] turn_trig_in,
   input wire logic cmp_on_read_in,
   input wire logic turn_on_modulus_in,
   input wire logic modulo_en_in,
   input wire logic [15:0] modulus_in,
   input wire logic [15:0] init_pos_in,
   input wire logic [15:0] compare_in,
   input wire logic [3:0] count_clk_div_exp_in,
   input wire logic [2:0] filter_clk_div_exp_in,
   input wire logic [2:0] filter_count_in,
   input wire logic [15:0] wdog_timeout_in,
   input wire logic wdog_en_in,
   input wire logic test_en_in,
   input wire logic test_negative_in,
   input wire logic [5:0] irq_enable_in,
   // Software accesses
   input wire logic read_counter_in,
   input wire logic [5:0] flag_clear_in,
   // Counter values
   output logic [15:0] position_out,
   output logic [15:0] position_hold_out,
   output logic [15:0] pos_diff_out,
   output logic [15:0] pos_diff_hold_out,
   output logic [15:0] turn_counter_out,
   output logic [15:0] turn_hold_out,
   // Timing values
   output logic [15:0] last_edge_time_out,
   output logic [15:0] last_edge_hold_out,
   output logic [15:0] period_out,
   output logic [15:0] period_buf_out,
   output logic [15:0] period_hold_out,
   // Status
   output logic [5:0] flags_out,
   output logic count_up_out,
   output logic [7:0] signal_status_out,
   output logic compare_hit_pulse_out,
   output logic irq_out
);
   // ----------------------------------------
   // Prescalers
   // ----------------------------------------
   logic [14:0] cclk_cnt_r;
   logic [6:0] fclk_cnt_r;
   logic count_tick;
   logic filt_tick;

   assign count_tick = (cclk_cnt_r & ((15'h1 << count_clk_div_exp_in) - 15'h1))
      == 15'h0;
   assign filt_tick = (fclk_cnt_r & ((7'h1 << filter_clk_div_exp_in) - 7'h1))
      == 7'h0;

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cclk_cnt_r <= 15'h0;
         fclk_cnt_r <= 7'h0;
      end
      else
      begin
         cclk_cnt_r <= cclk_cnt_r + 15'h1;
         fclk_cnt_r <= fclk_cnt_r + 7'h1;
      end
   end

   // ----------------------------------------
   // Self-test generator
   // ----------------------------------------
   logic [1:0] test_ph_r;
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         test_ph_r <= 2'h0;
      else if (test_en_in && count_tick)
         test_ph_r <= test_negative_in ? test_ph_r - 2'h1
            : test_ph_r + 2'h1;
   end
   // Gray sequence from a binary phase counter
   logic test_a;
   logic test_b;
   assign test_a = test_ph_r[1];
   assign test_b = test_ph_r[1] ^ test_ph_r[0];

   // ----------------------------------------
   // Input filters
   // ----------------------------------------
   logic [3:0] raw_in;
   logic [3:0] filt;
   assign raw_in = {test_en_in ? test_a : quad_chan_a_in,
                    test_en_in ? test_b : quad_chan_b_in,
                    turn_pulse_in, marker_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_filt
         qpd_filt_if fi ();
         assign fi.sample = filt_tick;
         assign fi.count = filter_count_in;
         assign fi.raw = raw_in[gi];
         assign filt[gi] = fi.filt;
         qpd_filter u_filt (.clk_in(clk_in), .arst_n_in(arst_n_in), .f(fi));
      end
   endgenerate

   // ----------------------------------------
   // Edge detection on filtered signals
   // ----------------------------------------
   logic [3:0] filt_d_r;
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         filt_d_r <= 4'h0;
      else
         filt_d_r <= filt;
   end
   logic mark_rise, mark_fall, turn_rise, turn_fall, a_rise;
   assign mark_rise = filt[0] & ~filt_d_r[0];
   assign mark_fall = ~filt[0] & filt_d_r[0];
   assign turn_rise = filt[1] & ~filt_d_r[1];
   assign turn_fall = ~filt[1] & filt_d_r[1];
   assign a_rise = filt[3] & ~filt_d_r[3];

   logic mark_init, turn_init, init_pos;
   assign mark_init = (marker_trig_in == qpd_pkg::TRIG_RISE && mark_rise) ||
      (marker_trig_in == qpd_pkg::TRIG_FALL && mark_fall);
   assign turn_init = (turn_trig_in == qpd_pkg::TRIG_RISE && turn_rise) ||
      (turn_trig_in == qpd_pkg::TRIG_FALL && turn_fall);
   assign init_pos = mark_init | turn_init;

   // ----------------------------------------
   // Step decode
   // ----------------------------------------
   logic step, step_up;
   logic [1:0] prev_ab, cur_ab;
   assign prev_ab = {filt_d_r[3], filt_d_r[2]};
   assign cur_ab = {filt[3], filt[2]};
   always_comb
   begin
      step = 1'b0;
      step_up = 1'b0;
      if (single_phase_in)
      begin
         step = a_rise;
         step_up = ~filt[2] ^ reverse_in;
      end
      else
      begin
         // Quadrature: one valid single-bit change per step
         case ({prev_ab, cur_ab})
            4'b0001, 4'b0111, 4'b1110, 4'b1000:
            begin
               step = 1'b1;
               step_up = ~reverse_in;
            end
            4'b0010, 4'b1011, 4'b1101, 4'b0100:
            begin
               step = 1'b1;
               step_up = reverse_in;
            end
            default:
            begin
               step = 1'b0;
               step_up = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Position, difference and turn counters
   // ----------------------------------------
   logic [15:0] pos_r, diff_r, turn_r;
   logic roll_over, roll_under, dir_r;
   assign roll_over = step && step_up && modulo_en_in && pos_r == modulus_in;
   assign roll_under = step && !step_up && modulo_en_in && pos_r == 16'h0;

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         pos_r <= qpd_pkg::POS_RESET;
      else if (init_pos)
         pos_r <= init_pos_in;
      else if (roll_over)
         pos_r <= 16'h0;
      else if (roll_under)
         pos_r <= modulus_in;
      else if (step)
         pos_r <= step_up ? pos_r + 16'h1 : pos_r - 16'h1;
   end

   // Difference counter clears on read, so it measures motion between reads
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         diff_r <= 16'h0;
      else if (read_counter_in)
         diff_r <= 16'h0;
      else if (step)
         diff_r <= step_up ? diff_r + 16'h1 : diff_r - 16'h1;
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         dir_r <= 1'b0;
      else if (step)
         dir_r <= step_up;
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         turn_r <= 16'h0;
      else if (turn_on_modulus_in)
      begin
         if (roll_over)
            turn_r <= turn_r + 16'h1;
         else if (roll_under)
            turn_r <= turn_r - 16'h1;
      end
      else if (turn_rise)
         turn_r <= dir_r ? turn_r + 16'h1 : turn_r - 16'h1;
   end

   // ----------------------------------------
   // Edge time and period measurement
   // ----------------------------------------
   logic [15:0] edge_time_r, period_r, period_buf_r;
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         edge_time_r <= 16'h0;
      else if (step)
         edge_time_r <= 16'h0;
      else if (count_tick && edge_time_r != 16'hFFFF)
         edge_time_r <= edge_time_r + 16'h1;
   end
   // Period runs between difference reads; saturates instead of wrapping
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         period_r <= 16'h0;
         period_buf_r <= 16'h0;
      end
      else if (read_counter_in)
      begin
         period_buf_r <= edge_time_r;
         period_r <= 16'h0;
      end
      else if (count_tick && period_r != 16'hFFFF)
         period_r <= period_r + 16'h1;
   end

   // ----------------------------------------
   // Snapshot holds on any counter read
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         position_hold_out <= 16'h0;
         pos_diff_hold_out <= 16'h0;
         turn_hold_out <= 16'h0;
         last_edge_hold_out <= 16'h0;
         period_hold_out <= 16'h0;
      end
      else if (read_counter_in)
      begin
         position_hold_out <= pos_r;
         pos_diff_hold_out <= diff_r;
         turn_hold_out <= turn_r;
         last_edge_hold_out <= edge_time_r;
         period_hold_out <= period_buf_r;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         position_out <= 16'h0;
         pos_diff_out <= 16'h0;
         turn_counter_out <= 16'h0;
         last_edge_time_out <= 16'h0;
         period_out <= 16'h0;
         period_buf_out <= 16'h0;
         count_up_out <= 1'b0;
         signal_status_out <= 8'h0;
      end
      else
      begin
         position_out <= pos_r;
         pos_diff_out <= diff_r;
         turn_counter_out <= turn_r;
         last_edge_time_out <= edge_time_r;
         period_out <= period_r;
         period_buf_out <= period_buf_r;
         count_up_out <= dir_r;
         signal_status_out <= {filt, raw_in};
      end
   end

   // ----------------------------------------
   // Watchdog, compare, flags and interrupt
   // ----------------------------------------
   logic [15:0] wdog_r;
   logic wdog_fire;
   assign wdog_fire = wdog_en_in && count_tick && wdog_r == wdog_timeout_in
      && wdog_timeout_in != 16'h0;
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         wdog_r <= 16'h0;
      else if (step || !wdog_en_in || wdog_fire)
         wdog_r <= 16'h0;
      else if (count_tick)
         wdog_r <= wdog_r + 16'h1;
   end

   logic cmp_hit;
   logic cmp_eq_d_r;
   logic cmp_eq;
   assign cmp_eq = pos_r == compare_in;
   // Match pulses on arrival at the value, not for as long as it sits there
   assign cmp_hit = cmp_on_read_in ? read_counter_in
      : (cmp_eq && !cmp_eq_d_r);

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cmp_eq_d_r <= 1'b0;
         compare_hit_pulse_out <= 1'b0;
      end
      else
      begin
         cmp_eq_d_r <= cmp_eq;
         compare_hit_pulse_out <= cmp_hit;
      end
   end

   logic [5:0] events;
   assign events = {roll_under, roll_over, cmp_hit, wdog_fire,
                    turn_rise | turn_fall, mark_rise | mark_fall};

   // Set beats clear in the same cycle so no event is lost
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         flags_out <= 6'h0;
      else
         flags_out <= events | (flags_out & ~flag_clear_in);
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         irq_out <= 1'b0;
      else
         irq_out <= |((events | (flags_out & ~flag_clear_in))
            & irq_enable_in);
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_snap_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      read_counter_in |=> position_hold_out == $past(pos_r)
         && turn_hold_out == $past(turn_r)) else $error("snapshot wrong");
   a_flag_sticky: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      flags_out[0] && !flag_clear_in[0] |=> flags_out[0])
      else $error("flag dropped");
   a_irq_gate: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ##1 irq_out == |(flags_out & $past(irq_enable_in)))
      else $error("irq mismatch");
   a_cmp_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      cmp_on_read_in && read_counter_in |=> compare_hit_pulse_out)
      else $error("read pulse missing");
   a_mark_init: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      mark_init |=> pos_r == $past(init_pos_in))
      else $error("marker init failed");
   a_single_up: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      single_phase_in && a_rise && !init_pos && !roll_over && !roll_under
      && !filt[2] && !reverse_in |=> pos_r == $past(pos_r) + 16'h1)
      else $error("single up failed");
   a_turn_mod: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      turn_on_modulus_in && roll_over |=> turn_r == $past(turn_r) + 16'h1)
      else $error("turn roll failed");
   a_dir_track: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      step |=> ##1 count_up_out == $past(step_up, 2))
      else $error("direction stale");
endmodule // qpd_decoder

// File: rtl/qpd_filter.sv
`timescale 1ns/10ps
module qpd_filter
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Filter port
   qpd_filt_if.filt_end f
);
   logic filt_r;
   logic [3:0] agree_r;

   // ----------------------------------------
   // Agreement counter
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         filt_r <= 1'b0;
         agree_r <= 4'h0;
      end
      else if (f.sample)
      begin
         if (f.raw == filt_r)
            agree_r <= 4'h0;
         else if (agree_r + 4'h1 >= {1'b0, f.count} + qpd_pkg::FILT_MIN_SAMPLES)
         begin
            filt_r <= f.raw;
            agree_r <= 4'h0;
         end
         else
            agree_r <= agree_r + 4'h1;
      end
   end
   assign f.filt = filt_r;

   a_filt_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !f.sample |=> $stable(filt_r)) else $error("filter moved off sample");
endmodule // qpd_filter

// File: sim/qpd_encoder_model.sv
`timescale 1ns/10ps
module qpd_encoder_model
(
   // Pacing clock
   input wire logic clk_in,
   // Encoder lines
   output logic quad_chan_a_out,
   output logic quad_chan_b_out,
   output logic marker_out,
   output logic turn_pulse_out
);
   // ----------------------------------------
   // Shaft state
   // ----------------------------------------
   // Lines move after a falling edge, away from the sampling edge
   initial
   begin
      quad_chan_a_out = 1'b0;
      quad_chan_b_out = 1'b0;
      marker_out = 1'b0;
      turn_pulse_out = 1'b0;
   end
   task automatic set_ab(input logic a, input logic b);
      @(negedge clk_in);
      quad_chan_a_out = a;
      quad_chan_b_out = b;
      repeat (12) @(negedge clk_in);
   endtask
   // One bit per step, so the sensor never makes an illegal jump
   task automatic step(input logic up);
      if (up)
         set_ab(quad_chan_b_out, ~quad_chan_a_out);
      else
         set_ab(~quad_chan_b_out, quad_chan_a_out);
   endtask
   task automatic set_lines(input logic mark, input logic turn, input int hold);
      @(negedge clk_in);
      marker_out = mark;
      turn_pulse_out = turn;
      repeat (hold) @(negedge clk_in);
   endtask
endmodule // qpd_encoder_model

// File: sim/test_quadrature_position_decoder.sv
`timescale 1ns/10ps
module test_quadrature_position_decoder;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic sp = 1'b0, turn_counter = 1'b0, cmp_rd = 1'b0, turn_mod = 1'b0, mod_en = 1'b0;
   logic test_en = 1'b0, test_neg = 1'b0, rd = 1'b0, bad;
   logic [1:0] mark_trig = 2'h0, turn_trig = 2'h0;
   logic [15:0] modulus = 16'h0000, init_pos = 16'h0000, compare = 16'hFFFF;
   logic [3:0] cnt_exp = 4'h0;
   logic [2:0] filt_cnt = 3'h0;
   logic [5:0] irq_en = 6'h00, fclr = 6'h00;
   logic a, b, mk, tp, up, hit, irq;
   logic [15:0] pos, pos_h, diff, turn, turn_h, p0;
   logic [15:0] diff_h, edge_t, edge_h, per, per_b, per_h;
   logic [15:0] wdog_to = 16'h0010;
   logic [2:0] filt_exp = 3'h0;
   logic wdog_en = 1'b0;
   logic signed [15:0] sd;
   logic [5:0] flags;
   logic [7:0] status;
   int mismatches = 0, compares = 0, hits = 0, h0, exp_pos = 0;

   qpd_encoder_model enc (.clk_in(clk_in), .quad_chan_a_out(a),
      .quad_chan_b_out(b), .marker_out(mk), .turn_pulse_out(tp));
   qpd_decoder dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .quad_chan_a_in(a), .quad_chan_b_in(b), .marker_in(mk),
      .turn_pulse_in(tp), .single_phase_in(sp), .reverse_in(turn_counter),
      .marker_trig_in(mark_trig), .turn_trig_in(turn_trig),
      .cmp_on_read_in(cmp_rd), .turn_on_modulus_in(turn_mod),
      .modulo_en_in(mod_en), .modulus_in(modulus), .init_pos_in(init_pos),
      .compare_in(compare), .count_clk_div_exp_in(cnt_exp),
      .filter_clk_div_exp_in(filt_exp), .filter_count_in(filt_cnt),
      .wdog_timeout_in(wdog_to), .wdog_en_in(wdog_en), .test_en_in(test_en),
      .test_negative_in(test_neg), .irq_enable_in(irq_en),
      .read_counter_in(rd), .flag_clear_in(fclr), .position_out(pos),
      .position_hold_out(pos_h), .pos_diff_out(diff),
      .pos_diff_hold_out(diff_h), .turn_counter_out(turn),
      .turn_hold_out(turn_h), .last_edge_time_out(edge_t),
      .last_edge_hold_out(edge_h), .period_out(per), .period_buf_out(per_b),
      .period_hold_out(per_h), .flags_out(flags),
      .count_up_out(up), .signal_status_out(status),
      .compare_hit_pulse_out(hit), .irq_out(irq));

   // ----------------------------------------
   // Clock, pulse counter, helpers
   // ----------------------------------------
   initial
   begin
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
      if (hit === 1'b1)
         hits <= hits + 1;
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input logic dir);
      enc.step(dir);
      exp_pos = dir ? exp_pos + 1 : exp_pos - 1;
   endtask
   task automatic clr;
      fclr = 6'h3F;
      tick(1);
      fclr = 6'h00;
      tick(2);
   endtask
   task automatic read_pulse;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(3);
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_quad;
      chk("position reset", 16'h0000, pos);
      repeat (4) step(1'b1);
      chk("position up", 16'(exp_pos), pos);
      chk("direction up", 16'h0001, {15'h0000, up});
      repeat (2) step(1'b0);
      chk("position down", 16'(exp_pos), pos);
      chk("direction down", 16'h0000, {15'h0000, up});
   endtask
   task automatic t_single;
      sp = 1'b1;
      enc.set_ab(1'b0, 1'b0);
      enc.set_ab(1'b1, 1'b0);
      chk("single b low", 16'(exp_pos + 1), pos);
      enc.set_ab(1'b0, 1'b0);
      enc.set_ab(1'b0, 1'b1);
      enc.set_ab(1'b1, 1'b1);
      chk("single b high", 16'(exp_pos), pos);
      enc.set_ab(1'b0, 1'b0);
      turn_counter = 1'b1;
      enc.set_ab(1'b1, 1'b0);
      chk("single reversed", 16'(exp_pos - 1), pos);
      exp_pos = exp_pos - 1;
      sp = 1'b0;
      turn_counter = 1'b0;
   endtask
   task automatic t_trig;
      init_pos = 16'h0055;
      mark_trig = qpd_pkg::TRIG_RISE;
      irq_en = 6'h01;
      enc.set_lines(1'b1, 1'b0, 12);
      chk("marker init", 16'h0055, pos);
      chk("marker flag", 16'h0001, {10'h000, flags});
      chk("irq enabled", 16'h0001, {15'h0000, irq});
      exp_pos = 16'h0055;
      step(1'b1);
      enc.set_lines(1'b0, 1'b0, 12);
      chk("marker fall", 16'h0056, pos);
      clr();
      chk("flags cleared", 16'h0000, {10'h000, flags});
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      mark_trig = qpd_pkg::TRIG_OFF;
      turn_trig = qpd_pkg::TRIG_FALL;
      init_pos = 16'h0022;
      irq_en = 6'h00;
      enc.set_lines(1'b0, 1'b1, 12);
      chk("turn rise", 16'h0056, pos);
      chk("turn count", 16'h0001, turn);
      chk("turn flag", 16'h0001, {15'h0000, flags[qpd_pkg::FLG_TURN]});
      chk("irq masked", 16'h0000, {15'h0000, irq});
      enc.set_lines(1'b0, 1'b0, 12);
      chk("turn fall init", 16'h0022, pos);
      exp_pos = 16'h0022;
      turn_trig = qpd_pkg::TRIG_OFF;
      clr();
   endtask
   task automatic t_read_cmp;
      cmp_rd = 1'b1;
      step(1'b1);
      h0 = hits;
      read_pulse();
      chk("read pulse", 16'h0001, 16'(hits - h0));
      chk("position hold", 16'h0023, pos_h);
      chk("turn hold", 16'h0001, turn_h);
      chk("difference cleared", 16'h0000, diff);
      chk("difference hold", 16'h0003, diff_h);
      chk("edge time hold", 16'h0008, edge_h);
      chk("period buffer", 16'h0008, per_b);
      cmp_rd = 1'b0;
      compare = 16'h0024;
      irq_en = 6'h08;
      h0 = hits;
      step(1'b1);
      chk("match pulse", 16'h0001, 16'(hits - h0));
      chk("match flag", 16'h0001, {15'h0000, flags[qpd_pkg::FLG_CMP]});
      chk("match irq", 16'h0001, {15'h0000, irq});
      h0 = hits;
      read_pulse();
      chk("no read pulse", 16'h0000, 16'(hits - h0));
      chk("position hold 2", 16'h0024, pos_h);
      chk("difference hold 2", 16'h0001, diff_h);
      chk("edge time hold 2", 16'h0008, edge_h);
      chk("period hold", 16'h0008, per_h);
      chk("period restart", 16'h0002, per);
      chk("edge time", 16'h000B, edge_t);
      compare = 16'hFFFF;
      clr();
   endtask
   task automatic t_modulus;
      mod_en = 1'b1;
      modulus = 16'h0025;
      turn_mod = 1'b1;
      step(1'b1);
      step(1'b1);
      chk("wrap up", 16'h0000, pos);
      chk("roll over", 16'h0001, {15'h0000, flags[qpd_pkg::FLG_ROVR]});
      chk("turn on over", 16'h0002, turn);
      step(1'b0);
      chk("wrap down", 16'h0025, pos);
      chk("roll under", 16'h0001, {15'h0000, flags[qpd_pkg::FLG_RUND]});
      chk("turn on under", 16'h0001, turn);
      mod_en = 1'b0;
      turn_mod = 1'b0;
      clr();
   endtask
   task automatic t_filter;
      filt_cnt = 3'h7;
      bad = 1'b0;
      fork
         begin
            enc.set_lines(1'b1, 1'b0, 5);
            enc.set_lines(1'b0, 1'b0, 14);
         end
         repeat (20)
         begin
            @(posedge clk_in);
            if (status[4] !== 1'b0)
               bad = 1'b1;
         end
      join
      chk("glitch blocked", 16'h0000, {15'h0000, bad});
      enc.set_lines(1'b1, 1'b0, 8);
      chk("before ten", 16'h0000, {15'h0000, status[4]});
      tick(6);
      chk("status", {8'h00, a, b, 2'h1, a, b, 2'h1}, {8'h00, status});
      enc.set_lines(1'b0, 1'b0, 14);
      filt_cnt = 3'h0;
      // Sampling every fourth clock stretches three samples past eight clocks
      filt_exp = 3'h2;
      enc.set_lines(1'b1, 1'b0, 8);
      chk("slow filter early", 16'h0000, {15'h0000, status[4]});
      tick(6);
      chk("slow filter late", 16'h0001, {15'h0000, status[4]});
      enc.set_lines(1'b0, 1'b0, 14);
      filt_exp = 3'h0;
      clr();
   endtask
   task automatic t_wdog;
      wdog_en = 1'b1;
      irq_en = 6'h04;
      tick(10);
      chk("watchdog early", 16'h0000,
          {15'h0000, flags[qpd_pkg::FLG_WDOG]});
      tick(10);
      chk("watchdog flag", 16'h0001,
          {15'h0000, flags[qpd_pkg::FLG_WDOG]});
      chk("watchdog irq", 16'h0001, {15'h0000, irq});
      wdog_en = 1'b0;
      irq_en = 6'h00;
      clr();
   endtask
   task automatic t_self(input logic neg);
      test_neg = neg;
      test_en = 1'b1;
      cnt_exp = 4'h3;
      tick(8);
      p0 = pos;
      tick(256);
      sd = pos - p0;
      compares++;
      if ((neg ? -sd : sd) < 31 || (neg ? -sd : sd) > 33)
      begin
         mismatches++;
         $display("MISMATCH self test steps expected 32 seen %0d", sd);
      end
      chk("self test dir", {15'h0000, ~neg}, {15'h0000, up});
      test_en = 1'b0;
      tick(8);
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      tick(6);
      arst_n_in = 1'b1;
      tick(2);
      t_quad();
      t_single();
      t_trig();
      t_read_cmp();
      t_modulus();
      t_filter();
      t_wdog();
      t_self(1'b0);
      t_self(1'b1);
      print_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      mismatches++;
      print_verdict();
   end
endmodule // test_quadrature_position_decoder
